//--- hw/disk_port_pkg.sv
// Operation
// R1: enable false means drives ignore all inputs
// R2: only the addressed drive responds when enabled
// R3: unit select is binary 0..3, lsb first
// R4: chain outputs gated; radial status always active
// R5: register select 0 unused,1 head,2 low,3 control
// R6: registers 1 and 2 load on strobe fall
// R7: control bits act only while strobe true; fault clear stays active 32 cycles after strobe falls
// R8: host holds register select stable during strobe
// R9: input bus eight bits, bit zero lsb
// R10: reg1 low nibble head, high nibble cylinder top
// R11: reg2 loads cylinder low byte, starts seek
// R12: invalid cylinder sets illegal and seek complete
// R13: valid cylinder clears illegal, moves, completes
// R14: control bits: 0 write,2 in,3 out,4 clear,5 recal
// R15: write only with enable, ready, no unsafe
// R16: offset plus shifts heads inward quarter track
// R17: offset minus shifts heads outward quarter track
// R18: host waits settling time after offset change
// R19: fault clear pulse at least 250 ns
// R20: recalibrate clears status, goes to zero, completes
// R21: write pulse rising edge flips head current
// R22: ready only after load and without fault
// R23: write while unready or off track sets fault
// R24: cylinder above maximum count is invalid
package disk_port_pkg;
	localparam logic [1:0] REG_UNUSED = 2'h0;
	localparam logic [1:0] REG_HEAD_CYL_HIGH = 2'h1;
	localparam logic [1:0] REG_CYL_LOW = 2'h2;
	localparam logic [1:0] REG_CONTROL = 2'h3;
	localparam int CTL_WRITE_EN = 0;
	localparam int CTL_OFFSET_INWARD = 2;
	localparam int CTL_OFFSET_OUTWARD = 3;
	localparam int CTL_FAULT_CLEAR = 4;
	localparam int CTL_RECAL = 5;
	localparam int PULSE_MIN_NS = 250;
	localparam int CLK_PERIOD_NS = 8;
	localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] MAX_CYLINDER = 12'h243;
	localparam logic [7:0] SEEK_CYC = 8'h10;
	localparam logic [7:0] LOAD_CYC = 8'h20;
	localparam logic [11:0] CYL_RESET = 12'h000;
	localparam logic [3:0] HEAD_RESET = 4'h0;
endpackage

//--- hw/disk_port_if.sv
`timescale 1ns/100ps
interface disk_port_if;
	logic enable;
	logic unit_select_lsb;
	logic unit_select_msb;
	logic reg_select_lsb;
	logic reg_select_msb;
	logic input_strobe;
	logic [7:0] command_input_lines;
	logic write_flux_pulses;
	logic ready;
	logic ready_oe;
	logic fault;
	logic seek_complete;
	logic illegal_cylinder;
	modport host (output enable, unit_select_lsb, unit_select_msb, reg_select_lsb,
		reg_select_msb, input_strobe, command_input_lines, write_flux_pulses,
		input ready, ready_oe, fault, seek_complete, illegal_cylinder);
	modport drive (input enable, unit_select_lsb, unit_select_msb, reg_select_lsb,
		reg_select_msb, input_strobe, command_input_lines, write_flux_pulses,
		output ready, ready_oe, fault, seek_complete, illegal_cylinder);
endinterface

//--- hw/pulse_stretch.sv
`timescale 1ns/100ps
// holds a level high for a minimum number of cycles after a start pulse
module pulse_stretch import disk_port_pkg::*; (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// control
	input wire logic start_i,
	output logic level_o
);
	typedef struct packed {
		logic [7:0] count;
		logic level;
	} stretch_state_t;
	stretch_state_t st, next_st;
	always_comb begin
		next_st = st;
		if (start_i) begin
			next_st.count = 8'(PULSE_MIN_CYC);
			next_st.level = 1'b1;
		end else if (st.count > 8'h01) begin
			next_st.count = st.count - 8'h01;
		end else begin
			next_st.count = 8'h00;
			next_st.level = 1'b0;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign level_o = st.level;
endmodule

//--- hw/disk_drive_end.sv
`timescale 1ns/100ps
module disk_drive_end import disk_port_pkg::*; (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// strap and plant status
	input wire logic [1:0] unit_address_i,
	input wire logic load_done_i,
	input wire logic plant_fault_i,
	input wire logic on_track_i,
	// link
	disk_port_if.drive link,
	// mechanics side
	output logic [3:0] head_number_o,
	output logic [11:0] target_cylinder_o,
	output logic [11:0] current_cylinder_o,
	output logic offset_inward_o,
	output logic offset_outward_o,
	output logic write_gate_o,
	output logic write_current_o
);
	typedef enum logic [1:0] {IDLE, SEEKING, RECAL} seek_state_t;
	typedef struct packed {
		seek_state_t mode;
		logic [7:0] timer;
		logic [3:0] head_number;
		logic [3:0] cylinder_upper_nibble;
		logic [7:0] cylinder_lower_byte;
		logic [11:0] cylinder;
		logic strobe_d;
		logic [1:0] reg_d;
		logic flux_d;
		logic fault;
		logic seek_complete;
		logic illegal;
		logic ready;
		logic ready_oe;
		logic offset_in;
		logic offset_out;
		logic write_gate;
		logic write_current;
		logic load_done;
		logic recal_d;
	} drive_state_t;
	drive_state_t st, next_st;
	logic selected, strobe, clear_hold, recal_hold;
	logic [1:0] reg_sel;
	logic [7:0] bus;
	logic ctl_active;
	logic [11:0] demand;
	assign selected = link.enable && (unit_address_i ==
		{link.unit_select_msb, link.unit_select_lsb}); // see R1 see R2 see R3
	assign reg_sel = {link.reg_select_msb, link.reg_select_lsb}; // see R5
	assign strobe = selected && link.input_strobe;
	assign bus = link.command_input_lines; // see R9
	assign ctl_active = strobe && (reg_sel == REG_CONTROL); // see R7
	assign demand = {st.cylinder_upper_nibble, bus};
	pulse_stretch u_clear (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.start_i(ctl_active && bus[CTL_FAULT_CLEAR]),
		.level_o(clear_hold)
	);
	pulse_stretch u_recal (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.start_i(ctl_active && bus[CTL_RECAL]),
		.level_o(recal_hold)
	);
	always_comb begin
		logic wen;
		logic fall;
		wen = 1'b0;
		fall = 1'b0;
		next_st = st;
		next_st.strobe_d = strobe;
		next_st.reg_d = reg_sel;
		next_st.flux_d = link.write_flux_pulses;
		next_st.load_done = load_done_i;
		next_st.recal_d = recal_hold;
		fall = st.strobe_d && !strobe; // see R6
		wen = ctl_active && bus[CTL_WRITE_EN]; // see R14
		next_st.offset_in = ctl_active && bus[CTL_OFFSET_INWARD]; // see R16
		next_st.offset_out = ctl_active && bus[CTL_OFFSET_OUTWARD]; // see R17
		if (plant_fault_i) begin
			next_st.fault = 1'b1;
		end else if (wen && (!st.ready || !on_track_i)) begin
			next_st.fault = 1'b1; // see R23
		end else if (clear_hold) begin
			next_st.fault = 1'b0; // see R19
		end
		next_st.ready = st.load_done && !st.fault; // see R22
		next_st.ready_oe = selected; // see R4
		next_st.write_gate = wen && st.ready && on_track_i && !st.fault; // see R15
		if (st.write_gate && link.write_flux_pulses && !st.flux_d) begin
			next_st.write_current = !st.write_current; // see R21
		end
		if (fall && st.reg_d == REG_HEAD_CYL_HIGH) begin
			next_st.head_number = bus[3:0]; // see R10
			next_st.cylinder_upper_nibble = bus[7:4];
		end
		unique case (st.mode)
			IDLE: begin
				// only the rising edge starts a restore: the stretched level outlives one recal
				if (recal_hold && !st.recal_d && st.ready) begin
					next_st.seek_complete = 1'b0; // see R20
					next_st.illegal = 1'b0;
					next_st.timer = LOAD_CYC;
					next_st.mode = RECAL;
				end else if (fall && st.reg_d == REG_CYL_LOW && st.ready) begin
					next_st.cylinder_lower_byte = bus; // see R11
					next_st.seek_complete = 1'b0;
					if (demand > MAX_CYLINDER) begin
						next_st.illegal = 1'b1; // see R24 see R12
						next_st.seek_complete = 1'b1;
					end else begin
						next_st.illegal = 1'b0; // see R13
						next_st.cylinder = demand;
						next_st.timer = SEEK_CYC;
						next_st.mode = SEEKING;
					end
				end
			end
			SEEKING, RECAL: begin
				if (st.mode == RECAL) begin
					next_st.cylinder = CYL_RESET;
				end
				if (st.timer == 8'h00) begin
					next_st.seek_complete = 1'b1;
					next_st.mode = IDLE;
				end else begin
					next_st.timer = st.timer - 8'h01;
				end
			end
		endcase
	end
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			st <= '0;
			st.head_number <= HEAD_RESET;
			st.cylinder <= CYL_RESET;
			st.mode <= IDLE;
		end else begin
			st <= next_st;
		end
	end
	assign link.ready = st.ready;
	assign link.ready_oe = st.ready_oe;
	assign link.fault = st.fault;
	assign link.seek_complete = st.seek_complete;
	assign link.illegal_cylinder = st.illegal;
	assign head_number_o = st.head_number;
	assign target_cylinder_o = {st.cylinder_upper_nibble, st.cylinder_lower_byte};
	assign current_cylinder_o = st.cylinder;
	assign offset_inward_o = st.offset_in;
	assign offset_outward_o = st.offset_out;
	assign write_gate_o = st.write_gate;
	assign write_current_o = st.write_current;
endmodule

//--- hw/disk_host_end.sv
`timescale 1ns/100ps
module disk_host_end import disk_port_pkg::*; (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// command port
	input wire logic cmd_valid_i,
	input wire logic [1:0] cmd_unit_i,
	input wire logic [1:0] cmd_reg_i,
	input wire logic [7:0] cmd_data_i,
	input wire logic flux_i,
	output logic cmd_ready_o,
	output logic seek_complete_o,
	output logic illegal_o,
	// link
	disk_port_if.host link
);
	typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} host_state_t;
	typedef struct packed {
		host_state_t mode;
		logic [7:0] count;
		logic [1:0] unit;
		logic [1:0] reg_sel;
		logic [7:0] data;
		logic strobe;
		logic enable;
		logic flux;
		logic busy;
		logic skc;
		logic ill;
	} host_state_s_t;
	host_state_s_t st, next_st;
	always_comb begin
		next_st = st;
		next_st.flux = flux_i;
		next_st.skc = link.seek_complete;
		next_st.ill = link.illegal_cylinder;
		unique case (st.mode)
			IDLE: begin
				next_st.enable = 1'b1;
				if (cmd_valid_i) begin
					next_st.unit = cmd_unit_i;
					next_st.reg_sel = cmd_reg_i;
					next_st.data = cmd_data_i;
					next_st.busy = 1'b1;
					next_st.mode = SETUP;
				end
			end
			SETUP: begin
				next_st.strobe = 1'b1;
				next_st.count = 8'(PULSE_MIN_CYC); // see R19 see R20
				next_st.mode = STROBE;
			end
			STROBE: begin
				if (st.count == 8'h01) begin
					next_st.strobe = 1'b0;
					next_st.mode = HOLD;
				end else begin
					next_st.count = st.count - 8'h01;
				end
			end
			HOLD: begin
				next_st.busy = 1'b0; // see R8
				next_st.mode = IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			st <= '0;
			st.mode <= IDLE;
		end else begin
			st <= next_st;
		end
	end
	assign link.enable = st.enable; // see R1
	assign link.unit_select_lsb = st.unit[0];
	assign link.unit_select_msb = st.unit[1];
	assign link.reg_select_lsb = st.reg_sel[0];
	assign link.reg_select_msb = st.reg_sel[1];
	assign link.input_strobe = st.strobe;
	assign link.command_input_lines = st.data; // see R9
	assign link.write_flux_pulses = st.flux;
	assign cmd_ready_o = !st.busy;
	assign seek_complete_o = st.skc;
	assign illegal_o = st.ill;
endmodule

//--- verification/disk_port_properties.sv
`timescale 1ns/100ps
module disk_port_properties #(parameter logic [1:0] UNIT = 2'h1) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// link from host
	input wire logic enable,
	input wire logic unit_select_lsb,
	input wire logic unit_select_msb,
	input wire logic reg_select_lsb,
	input wire logic reg_select_msb,
	input wire logic input_strobe,
	input wire logic [7:0] command_input_lines,
	input wire logic write_flux_pulses,
	// link from drive
	input wire logic ready,
	input wire logic ready_oe,
	input wire logic fault,
	input wire logic seek_complete,
	input wire logic illegal_cylinder
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	wire logic sel = enable && {unit_select_msb, unit_select_lsb} == UNIT;
	wire logic [1:0] rsel = {reg_select_msb, reg_select_lsb};
	// ================================================================
	// selection
	property p_oe_off; !sel |=> !ready_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("chain output on while unselected");
	property p_oe_on; sel |=> ready_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("chain output off while selected");
	// ================================================================
	// strobe framing
	property p_reg_stable; input_strobe && $past(input_strobe) |-> rsel == $past(rsel); endproperty
	a_reg_stable: assert property (p_reg_stable) else $error("register select moved");
	property p_strobe_len; $rose(input_strobe) |=> input_strobe [*8]; endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("strobe too short");
	// ================================================================
	// seek and ready status
	property p_seek_start;
		$fell(input_strobe) && sel && rsel == 2'h2 && ready && seek_complete
			|-> ##[1:4] (!seek_complete || illegal_cylinder);
	endproperty
	a_seek_start: assert property (p_seek_start) else $error("seek did not start");
	property p_seek_end; $fell(seek_complete) |-> ##[1:200] seek_complete; endproperty
	a_seek_end: assert property (p_seek_end) else $error("seek never completed");
	property p_illegal_cmp; $rose(illegal_cylinder) |-> seek_complete; endproperty
	a_illegal_cmp: assert property (p_illegal_cmp) else $error("illegal without complete");
	property p_ready_ok; $rose(ready) |-> !fault; endproperty
	a_ready_ok: assert property (p_ready_ok) else $error("ready rose with fault");
endmodule

//--- verification/tb.sv
`timescale 1ns/100ps
module tb;
	import disk_port_pkg::*;
	localparam logic [1:0] UNIT = 2'h1;
	logic clk_sys_i = 0, nrst_i = 0, cmd_valid_i = 0, flux_i = 0;
	logic load_done = 0, on_track = 1, w;
	logic [1:0] cmd_unit_i = UNIT, cmd_reg_i = 2'h0;
	logic [7:0] cmd_data_i = 8'h00;
	logic cmd_ready_o, oin, oout, wg, wc;
	logic [3:0] head;
	logic [11:0] tgt, cur, c;
	int mismatches = 0, checks = 0;
	integer seed = 32'h21fe;
	always #4 clk_sys_i = ~clk_sys_i;
	disk_port_if link ();
	disk_host_end disk_host_end_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.cmd_valid_i(cmd_valid_i), .cmd_unit_i(cmd_unit_i), .cmd_reg_i(cmd_reg_i),
		.cmd_data_i(cmd_data_i), .flux_i(flux_i), .cmd_ready_o(cmd_ready_o),
		.seek_complete_o(), .illegal_o(), .link(link));
	disk_drive_end disk_drive_end_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.unit_address_i(UNIT), .load_done_i(load_done), .plant_fault_i(1'b0),
		.on_track_i(on_track), .link(link), .head_number_o(head), .target_cylinder_o(tgt),
		.current_cylinder_o(cur), .offset_inward_o(oin), .offset_outward_o(oout),
		.write_gate_o(wg), .write_current_o(wc));
	disk_port_properties #(.UNIT(UNIT)) disk_port_properties_inst (.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i), .enable(link.enable), .unit_select_lsb(link.unit_select_lsb),
		.unit_select_msb(link.unit_select_msb), .reg_select_lsb(link.reg_select_lsb),
		.reg_select_msb(link.reg_select_msb), .input_strobe(link.input_strobe),
		.command_input_lines(link.command_input_lines),
		.write_flux_pulses(link.write_flux_pulses), .ready(link.ready),
		.ready_oe(link.ready_oe), .fault(link.fault), .seek_complete(link.seek_complete),
		.illegal_cylinder(link.illegal_cylinder));
	// ================================================================
	// shared tasks
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic wait_rdy();
		for (int i = 0; i < 400 && cmd_ready_o !== 1'b1; i++) tick(1);
		chk("cmd_ready", 12'h001, {11'h000, cmd_ready_o});
	endtask
	task automatic wait_sc();
		for (int i = 0; i < 300 && link.seek_complete !== 1'b1; i++) tick(1);
		chk("seek_complete", 12'h001, {11'h000, link.seek_complete});
	endtask
	task automatic send(input logic [1:0] u, input logic [1:0] r, input logic [7:0] d);
		wait_rdy();
		cmd_unit_i = u;
		cmd_reg_i = r;
		cmd_data_i = d;
		cmd_valid_i = 1;
		tick(1);
		cmd_valid_i = 0;
	endtask
	task automatic seek(input logic [11:0] cy, input logic [3:0] hd);
		logic bad;
		bad = cy > MAX_CYLINDER;
		send(UNIT, REG_HEAD_CYL_HIGH, {cy[11:8], hd});
		send(UNIT, REG_CYL_LOW, cy[7:0]);
		wait_rdy();
		tick(4);
		wait_sc();
		chk("illegal", {11'h000, bad}, {11'h000, link.illegal_cylinder});
		chk("target", cy, tgt);
		chk("head", {8'h00, hd}, {8'h00, head});
		if (!bad) chk("position", cy, cur);
	endtask
	task automatic ctl(input logic [7:0] d);
		send(UNIT, REG_CONTROL, d);
		tick(10);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ================================================================
	// tests
	initial begin
		tick(2);
		nrst_i = 1;
		load_done = 1;
		tick(100);
		seek(12'h000, 4'h0);
		seek(MAX_CYLINDER, 4'hF);
		seek(MAX_CYLINDER + 12'h001, 4'h3);
		for (int i = 0; i < 6; i++) seek({2'h0, 10'($random(seed))}, 4'($random(seed)));
		$display("test seek done");
		c = tgt;
		send(UNIT ^ 2'h1, REG_CYL_LOW, 8'h5A);
		send(UNIT, REG_UNUSED, 8'hA5);
		wait_rdy();
		tick(4);
		chk("target", c, tgt);
		$display("test select done");
		for (int b = 2; b < 4; b++) begin
			ctl(8'(1 << b));
			chk("offset", 12'(b - 1), {10'h000, oout, oin});
			wait_rdy();
			tick(4);
			chk("offset", 12'h000, {10'h000, oout, oin});
		end
		ctl(8'h01);
		w = wc;
		chk("write_gate", 12'h001, {11'h000, wg});
		flux_i = 1;
		tick(3);
		flux_i = 0;
		chk("write_current", {11'h000, !w}, {11'h000, wc});
		wait_rdy();
		on_track = 0;
		ctl(8'h01);
		chk("write_gate", 12'h000, {11'h000, wg});
		chk("fault", 12'h001, {11'h000, link.fault});
		on_track = 1;
		wait_rdy();
		ctl(8'h10);
		wait_rdy();
		tick(80);
		chk("fault", 12'h000, {11'h000, link.fault});
		chk("ready", 12'h001, {11'h000, link.ready});
		$display("test control done");
		seek(12'hFFF, 4'h1);
		ctl(8'h20);
		wait_rdy();
		tick(4);
		wait_sc();
		chk("position", 12'h000, cur);
		chk("illegal", 12'h000, {11'h000, link.illegal_cylinder});
		$display("test recal done");
		test_done();
	end
	initial begin
		#(8 * 20000);
		mismatches++;
		test_done();
	end
endmodule
